// ---- pctcr_pkg.sv ----
// Purpose: Shared constants for the secondary port clock and transmitter
//          configuration block.
// Assumes: Single 40 MHz clock, synchronous active-low reset.
// Notes:   Register offsets are the host serial interface addresses.
//
// Overview of operation
// - Word clock is master clock over 128/256/384/512.
// - Bit clock is always 64 times word clock.
// - Bits 3:2 pick external, receiver-in or recovered clock.
// - Bit 0 picks slip or block start trigger.
// - Usability flag goes into transmitted validity bit.
// - Separate select decides if usability flag is used.
// - Direction bit: block start pin input or output.
// - Transmitter divides its master clock by 128 to 512.
// - Transmitter clock: external or recovered master clock.
package pctcr_pkg;
    // Register map
    localparam logic [6:0] PCTCR_ADDR_SEC_CLK = 7'h06;
    localparam logic [6:0] PCTCR_ADDR_TX_CFG1 = 7'h07;
    // Reset values
    localparam logic [3:0] PCTCR_SEC_CLK_RESET = 4'h0;
    localparam logic [7:0] PCTCR_TX_CFG1_RESET = 8'h00;
    // Secondary port clock register fields
    localparam int PCTCR_SEC_DIV_LSB = 0;
    localparam int PCTCR_SEC_SRC_LSB = 2;
    // Transmitter config one fields
    localparam int PCTCR_TX_TRIG_BIT = 0;
    localparam int PCTCR_TX_VALID_BIT = 1;
    localparam int PCTCR_TX_BLSDIR_BIT = 2;
    localparam int PCTCR_TX_INSEL_LSB = 3;
    localparam int PCTCR_TX_DIV_LSB = 5;
    localparam int PCTCR_TX_CLKSRC_BIT = 7;
    // Clock source codes (index into the three clock pins)
    localparam logic [1:0] PCTCR_SRC_MCLK = 2'h0;
    localparam logic [1:0] PCTCR_SRC_RECEIVER_CLOCK_INPUT = 2'h1;
    localparam logic [1:0] PCTCR_SRC_RECOVERED_RECEIVER_CLOCK = 2'h2;
    // Transmitter input select codes
    localparam logic [1:0] PCTCR_IN_PRIMARY = 2'h0;
    localparam logic [1:0] PCTCR_IN_SECONDARY = 2'h1;
    localparam logic [1:0] PCTCR_IN_RECEIVER = 2'h2;
    // Divider geometry: 64 bit clocks per word, 128 toggles per word
    localparam int PCTCR_BITS_PER_WORD = 64;
    localparam int PCTCR_TOGGLE_CNT_W = 6;
    localparam int PCTCR_EDGE_CNT_W = 2;
endpackage

// ---- pctcr_clock_divider.sv ----
// Purpose: Picks one of three clock pins and divides it into bit clock,
//          word clock and a one-cycle frame tick.
// Assumes: Pin clocks are well below half of the 40 MHz system clock.
// Notes:   Source code 3 gives no edges, so the outputs freeze.
module pctcr_clock_divider
    import pctcr_pkg::*;
(
    // System
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Clock pins, asynchronous to clk_i
    input wire logic [2:0] clk_pins_i,
    // Control
    input wire logic enable_i,
    input wire logic [1:0] source_i,
    input wire logic [1:0] divider_code_i,
    // Generated clocks
    output logic bit_clk_o,
    output logic word_clk_o,
    output logic frame_tick_o
);
    logic [2:0] sync1_reg; // First stage, read only by second stage
    logic [2:0] sync2_reg; // Second stage, safe to use
    logic sel_prev_reg, sel_prev_next; // Edge detector memory
    logic [PCTCR_EDGE_CNT_W-1:0] edge_cnt_reg, edge_cnt_next;
    logic [PCTCR_TOGGLE_CNT_W-1:0] tog_cnt_reg, tog_cnt_next;
    logic bit_reg, bit_next;
    logic word_reg, word_next;
    logic tick_reg, tick_next;
    logic sel_level; // Selected synchronised clock level
    logic rise; // One-cycle rising edge of selected clock

    // Two-flop synchronisers for each clock pin
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            always_ff @(posedge clk_i) begin
                if (!reset_n_i) begin
                    sync1_reg[gi] <= 1'b0;
                    sync2_reg[gi] <= 1'b0;
                end else begin
                    sync1_reg[gi] <= clk_pins_i[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                end
            end
        end
    endgenerate

    // Source mux and divider; half a bit period is code+1 source edges,
    // giving a bit clock of 2/4/6/8 source periods and word of 64 bits
    always_comb begin
        sel_level = 1'b0;
        if (source_i != 2'h3) begin // Reserved source yields no edges
            sel_level = sync2_reg[source_i];
        end
        rise = sel_level & ~sel_prev_reg;
        sel_prev_next = sel_level;
        edge_cnt_next = edge_cnt_reg;
        tog_cnt_next = tog_cnt_reg;
        bit_next = bit_reg;
        word_next = word_reg;
        tick_next = 1'b0;
        if (!enable_i) begin
            // Held in a known phase while the port is slave
            edge_cnt_next = '0;
            tog_cnt_next = '0;
            bit_next = 1'b0;
            word_next = 1'b0;
        end else if (rise) begin
            if (edge_cnt_reg == divider_code_i) begin
                edge_cnt_next = '0;
                bit_next = ~bit_reg;
                tog_cnt_next = tog_cnt_reg + 1'b1;
                // 64 bit-clock toggles make half a word: 64x ratio
                if (tog_cnt_reg == '1) begin
                    word_next = ~word_reg;
                    tick_next = word_reg; // One tick per full word period
                end
            end else begin
                edge_cnt_next = edge_cnt_reg + 1'b1;
            end
        end
    end

    // Divider state registers
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            sel_prev_reg <= 1'b0;
            edge_cnt_reg <= '0;
            tog_cnt_reg <= '0;
            bit_reg <= 1'b0;
            word_reg <= 1'b0;
            tick_reg <= 1'b0;
        end else begin
            sel_prev_reg <= sel_prev_next;
            edge_cnt_reg <= edge_cnt_next;
            tog_cnt_reg <= tog_cnt_next;
            bit_reg <= bit_next;
            word_reg <= word_next;
            tick_reg <= tick_next;
        end
    end

    assign bit_clk_o = bit_reg;
    assign word_clk_o = word_reg;
    assign frame_tick_o = tick_reg;
endmodule

// ---- pctcr_top.sv ----
// Purpose: Secondary port clock register and transmitter config register
//          with the clock, validity, block start and slip logic they steer.
// Assumes: Host serial interface decodes to a byte write/read port here.
// Notes:   All outputs are registered; pins are synchronised first.
//          The upper nibble of the clock register is not stored, so it
//          always reads back as zero whatever software put there.
//          The transmitter divider runs at all times; the secondary one
//          is held in a fixed phase whenever the port is a slave.
//          Mode and validity source bits live in other registers and
//          arrive here as plain inputs on the system clock.
//          Pin clocks are sampled, so they must stay well below half
//          of the system clock or edges will be lost.
module pctcr_top
    import pctcr_pkg::*;
(
    // System
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Register port from the host serial interface
    input wire logic [6:0] reg_addr_i,
    input wire logic reg_write_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // Clock pins
    input wire logic master_clock_i,
    input wire logic receiver_clock_input_i,
    input wire logic recovered_receiver_clock_i,
    // Secondary port
    input wire logic secondary_master_mode_i,
    output logic secondary_bit_clock_o,
    output logic secondary_word_clock_o,
    // Transmitter audio sources and routing
    input wire logic primary_audio_i,
    input wire logic secondary_audio_i,
    input wire logic receiver_audio_i,
    output logic tx_audio_o,
    output logic [1:0] transmitter_input_select_o,
    output logic transmitter_frame_tick_o,
    // Validity
    input wire logic usability_source_select_i,
    input wire logic stream_validity_i,
    output logic tx_validity_o,
    // Block start pin, three signals
    input wire logic block_start_pin_i,
    output logic block_start_pin_o,
    output logic block_start_pin_oe_o,
    // Slip status
    input wire logic data_slip_i,
    input wire logic slip_flag_clear_i,
    output logic transmitter_slip_flag_o
);
    // Configuration storage
    logic [3:0] sec_clk_reg, sec_clk_next; // Low nibble of 0x06
    logic [7:0] tx_cfg_reg, tx_cfg_next; // Register 0x07
    // Read data, registered so the host sees a settled byte
    logic [7:0] rdata_reg, rdata_next;
    // Block start pin input path
    logic [1:0] bls_sync_reg; // Block start pin synchroniser
    logic bls_prev_reg, bls_prev_next;
    // Output flops, one per top-level output
    logic audio_reg, audio_next;
    logic valid_reg, valid_next;
    logic pin_o_reg, pin_o_next;
    logic pin_oe_reg, pin_oe_next;
    logic slip_reg, slip_next;
    logic [1:0] insel_reg, insel_next;
    // Internal nets between the dividers and the output logic
    logic [1:0] tx_src; // Transmitter clock source as mux code
    logic sec_bit, sec_word, tx_tick, tx_tick_reg;
    logic block_start; // Block start event
    logic trigger; // Selected slip flag trigger
    logic [2:0] clk_pins;

    assign clk_pins = {recovered_receiver_clock_i, receiver_clock_input_i,
                       master_clock_i};

    // Read decode shared by the read path
    // Kept as a function so the address map lives in one place
    function automatic logic [7:0] read_value(input logic [6:0] addr,
                                              input logic [3:0] sec,
                                              input logic [7:0] txc);
        read_value = 8'h00; // Unmapped addresses read zero
        if (addr == PCTCR_ADDR_SEC_CLK) begin
            read_value = {4'h0, sec}; // Upper bits always read zero
        end else if (addr == PCTCR_ADDR_TX_CFG1) begin
            read_value = txc;
        end
    endfunction

    // Secondary port clocks, run only in master mode
    // Slave mode holds both clocks low and restarts the phase cleanly
    pctcr_clock_divider u_sec_div (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .clk_pins_i(clk_pins),
        .enable_i(secondary_master_mode_i),
        .source_i(sec_clk_reg[PCTCR_SEC_SRC_LSB +: 2]),
        .divider_code_i(sec_clk_reg[PCTCR_SEC_DIV_LSB +: 2]),
        .bit_clk_o(sec_bit),
        .word_clk_o(sec_word),
        .frame_tick_o()
    );

    // Transmitter clock source: external or recovered master clock
    assign tx_src = tx_cfg_reg[PCTCR_TX_CLKSRC_BIT] ?
                    PCTCR_SRC_RECOVERED_RECEIVER_CLOCK : PCTCR_SRC_MCLK;

    // Transmitter frame rate divider
    // Only its frame tick is used; its clock outputs are left open
    pctcr_clock_divider u_tx_div (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .clk_pins_i(clk_pins),
        .enable_i(1'b1),
        .source_i(tx_src),
        .divider_code_i(tx_cfg_reg[PCTCR_TX_DIV_LSB +: 2]),
        .bit_clk_o(),
        .word_clk_o(),
        .frame_tick_o(tx_tick)
    );

    // Register writes and datapath next values
    // Every next value comes from the current register state, so a
    // write reaches the datapath one cycle after it is taken.
    always_comb begin
        sec_clk_next = sec_clk_reg;
        tx_cfg_next = tx_cfg_reg;
        if (reg_write_i && reg_addr_i == PCTCR_ADDR_SEC_CLK) begin
            // Upper nibble is not stored; software keeps it zero
            sec_clk_next = reg_wdata_i[3:0];
        end
        if (reg_write_i && reg_addr_i == PCTCR_ADDR_TX_CFG1) begin
            tx_cfg_next = reg_wdata_i;
        end
        rdata_next = read_value(reg_addr_i, sec_clk_reg, tx_cfg_reg);

        // Audio routing; reserved code sends silence
        // The select is registered out too, so routing can be observed
        insel_next = tx_cfg_reg[PCTCR_TX_INSEL_LSB +: 2];
        unique case (insel_next)
            PCTCR_IN_PRIMARY: audio_next = primary_audio_i;
            PCTCR_IN_SECONDARY: audio_next = secondary_audio_i;
            PCTCR_IN_RECEIVER: audio_next = receiver_audio_i;
            default: audio_next = 1'b0;
        endcase

        // Validity: register flag only when the separate select asks
        // Otherwise the stream's own validity passes through unchanged
        valid_next = usability_source_select_i ?
                     tx_cfg_reg[PCTCR_TX_VALID_BIT] :
                     stream_validity_i;

        // Block start pin: input mode listens, output mode drives frames
        // In output mode the pin edge detector is ignored, so a stray
        // level on the pin cannot set the slip flag.
        pin_oe_next = tx_cfg_reg[PCTCR_TX_BLSDIR_BIT];
        pin_o_next = pin_oe_next & tx_tick;
        bls_prev_next = bls_sync_reg[1];
        if (pin_oe_reg) begin
            block_start = tx_tick_reg;
        end else begin
            block_start = bls_sync_reg[1] & ~bls_prev_reg;
        end

        // Sticky slip flag; a new event beats a same-cycle clear
        // This way an event is never lost to a badly timed clear, at the
        // cost of one extra clear when both land together.
        trigger = tx_cfg_reg[PCTCR_TX_TRIG_BIT] ? block_start
                                                : data_slip_i;
        slip_next = slip_reg;
        if (slip_flag_clear_i) begin
            slip_next = 1'b0;
        end
        if (trigger) begin
            slip_next = 1'b1;
        end
    end

    // Registers, pin synchroniser and output flops
    // The reset branch loads constants only; the synchroniser's first
    // stage is read by nothing but its second stage.
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            sec_clk_reg <= PCTCR_SEC_CLK_RESET;
            tx_cfg_reg <= PCTCR_TX_CFG1_RESET;
            rdata_reg <= 8'h00;
            bls_sync_reg <= 2'h0;
            bls_prev_reg <= 1'b0;
            audio_reg <= 1'b0;
            valid_reg <= 1'b0;
            pin_o_reg <= 1'b0;
            pin_oe_reg <= 1'b0;
            slip_reg <= 1'b0;
            insel_reg <= 2'h0;
            tx_tick_reg <= 1'b0;
        end else begin
            sec_clk_reg <= sec_clk_next;
            tx_cfg_reg <= tx_cfg_next;
            rdata_reg <= rdata_next;
            bls_sync_reg <= {bls_sync_reg[0], block_start_pin_i};
            bls_prev_reg <= bls_prev_next;
            audio_reg <= audio_next;
            valid_reg <= valid_next;
            pin_o_reg <= pin_o_next;
            pin_oe_reg <= pin_oe_next;
            slip_reg <= slip_next;
            insel_reg <= insel_next;
            tx_tick_reg <= tx_tick;
        end
    end

    // Outputs straight from flops
    // No logic sits between these flops and the ports
    assign reg_rdata_o = rdata_reg;
    assign secondary_bit_clock_o = sec_bit;
    assign secondary_word_clock_o = sec_word;
    assign tx_audio_o = audio_reg;
    assign transmitter_input_select_o = insel_reg;
    assign transmitter_frame_tick_o = tx_tick_reg;
    assign tx_validity_o = valid_reg;
    assign block_start_pin_o = pin_o_reg;
    assign block_start_pin_oe_o = pin_oe_reg;
    assign transmitter_slip_flag_o = slip_reg;
endmodule

// ---- pctcr_props.sv ----
// Purpose: Port-level checks for pctcr_top.
// Assumes: One clock, synchronous active-low reset.
// Notes: Shadows two config bits from observed writes.
module pctcr_props
    import pctcr_pkg::*;
(
    // System and register port
    input wire logic clk_i, reset_n_i, reg_write_i,
    input wire logic [6:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i, reg_rdata_o,
    // Clocks, validity, slip, routing
    input wire logic secondary_master_mode_i, secondary_bit_clock_o,
    input wire logic secondary_word_clock_o, usability_source_select_i,
    input wire logic stream_validity_i, tx_validity_o, data_slip_i,
    input wire logic slip_flag_clear_i, transmitter_slip_flag_o,
    input wire logic block_start_pin_oe_o,
    input wire logic [1:0] transmitter_input_select_o
);
    timeunit 1ns;
    timeprecision 1ps;
    wire wr_tx = reg_write_i && reg_addr_i == PCTCR_ADDR_TX_CFG1;
    wire wr_sec = reg_write_i && reg_addr_i == PCTCR_ADDR_SEC_CLK;
    logic [1:0] cfg_reg; // Trigger and validity bits as the design holds them
    logic [1:0] cfg_next;
    // Shadow update, so slip and validity checks know the live setting
    always_comb begin
        cfg_next = cfg_reg;
        if (wr_tx) begin
            cfg_next = reg_wdata_i[1:0];
        end
    end
    always_ff @(posedge clk_i) begin
        cfg_reg <= reset_n_i ? cfg_next : 2'h0;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    a_tx_readback: assert property (
        wr_tx ##1 (!reg_write_i && reg_addr_i == PCTCR_ADDR_TX_CFG1)
        |=> reg_rdata_o == $past(reg_wdata_i, 2)) else $error("Bad readback");
    a_sec_readback: assert property (
        wr_sec ##1 (!reg_write_i && reg_addr_i == PCTCR_ADDR_SEC_CLK)
        |=> reg_rdata_o == {4'h0, $past(reg_wdata_i[3:0], 2)})
        else $error("Bad clock register readback");
    a_unmapped_zero: assert property (
        reg_addr_i != 7'h06 && reg_addr_i != 7'h07 |=> reg_rdata_o == 8'h00)
        else $error("Unmapped address read nonzero");
    a_insel_follows: assert property (
        wr_tx |=> ##1 transmitter_input_select_o == $past(reg_wdata_i[4:3], 2))
        else $error("Input select not updated");
    a_pin_direction: assert property (
        wr_tx |=> ##1 block_start_pin_oe_o == $past(reg_wdata_i[2], 2))
        else $error("Pin direction not updated");
    a_slip_sets: assert property (
        data_slip_i && !cfg_reg[0] |=> transmitter_slip_flag_o)
        else $error("Slip did not set flag");
    a_slip_clears: assert property (
        slip_flag_clear_i && !data_slip_i && !cfg_reg[0]
        |=> !transmitter_slip_flag_o) else $error("Flag not cleared");
    a_valid_from_reg: assert property (
        usability_source_select_i |=> tx_validity_o == $past(cfg_reg[1]))
        else $error("Validity not from register");
    a_valid_from_stream: assert property (
        !usability_source_select_i
        |=> tx_validity_o == $past(stream_validity_i))
        else $error("Validity not from stream");
    a_slave_clocks_low: assert property (
        !secondary_master_mode_i [*4] |-> !secondary_bit_clock_o
        && !secondary_word_clock_o) else $error("Clocks run in slave mode");
    c_tx_write: cover property (wr_tx);
    c_slip_seen: cover property ($rose(transmitter_slip_flag_o));
    c_word_clock: cover property ($rose(secondary_word_clock_o));
endmodule

// ---- tb_top.sv ----
// Purpose: Self-checking bench for pctcr_top.
// Assumes: 40 MHz clock; pin clocks have periods of 8, 6 and 4 cycles.
// Notes: Drivers queue expectations; a monitor pops and compares them.
module tb_top
    import pctcr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {int id; logic [31:0] v;} pctcr_exp_t;
    logic clk_i = 1'b0, reset_n_i = 1'b0, reg_write_i = 1'b0;
    logic [6:0] reg_addr_i = 7'h00;
    logic [7:0] reg_wdata_i = 8'h00, rdata;
    logic [2:0] pins = 3'h0, aud = 3'h0; // Pin clocks and audio bits
    logic smode = 1'b1, usel = 1'b0, sval = 1'b0, bs_pin = 1'b0;
    logic slip = 1'b0, clr = 1'b0, wq = 1'b0, bq = 1'b0;
    logic bclk, wclk, audio, tick, valid, bs_out, bs_oe, flag;
    logic [1:0] insel;
    logic [31:0] wper = 0, bper = 0, tper = 0, wat = 0, bat = 0, tat = 0;
    logic [31:0] pbad = 0; // Cycles where the pin output broke its rule
    logic [31:0] obs [0:9]; // Observed values, indexed like names
    int cyc = 0, wn = 0, tn = 0, failures = 0, checks_done = 0;
    pctcr_exp_t exp_q[$], cur;
    string names [0:9] = '{"rdata", "word_period", "bit_period",
        "tick_period", "audio", "insel", "validity", "slip_flag", "pin_oe",
        "pin_out_err"};
    pctcr_top pctcr_top_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .reg_addr_i(reg_addr_i), .reg_write_i(reg_write_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(rdata),
        .master_clock_i(pins[0]), .receiver_clock_input_i(pins[1]),
        .recovered_receiver_clock_i(pins[2]), .secondary_master_mode_i(smode),
        .secondary_bit_clock_o(bclk), .secondary_word_clock_o(wclk),
        .primary_audio_i(aud[0]), .secondary_audio_i(aud[1]),
        .receiver_audio_i(aud[2]), .tx_audio_o(audio),
        .transmitter_input_select_o(insel), .transmitter_frame_tick_o(tick),
        .usability_source_select_i(usel), .stream_validity_i(sval),
        .tx_validity_o(valid), .block_start_pin_i(bs_pin),
        .block_start_pin_o(bs_out), .block_start_pin_oe_o(bs_oe),
        .data_slip_i(slip), .slip_flag_clear_i(clr),
        .transmitter_slip_flag_o(flag));
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    always_comb obs = '{{24'h0, rdata}, wper, bper, tper, {31'h0, audio},
        {30'h0, insel}, {31'h0, valid}, {31'h0, flag}, {31'h0, bs_oe}, pbad};
    // Pin clocks, plus rise-to-rise periods of the generated clocks
    always @(posedge clk_i) begin
        pins <= {cyc % 4 < 2, cyc % 6 < 3, cyc % 8 < 4};
        cyc <= cyc + 1;
        wq <= wclk;
        bq <= bclk;
        if (wclk && !wq) begin
            wper <= cyc - wat;
            wat <= cyc;
            wn <= wn + 1;
        end
        if (bclk && !bq) begin
            bper <= cyc - bat;
            bat <= cyc;
        end
        // Output mode pulses the pin with each frame, input mode never
        if (reset_n_i && bs_out !== (bs_oe && tick)) begin
            pbad <= pbad + 1;
        end
        if (tick) begin
            tper <= cyc - tat;
            tat <= cyc;
            tn <= tn + 1;
        end
    end
    task automatic check(input string what, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    // Monitor: oldest expectation against what the outputs show now
    always @(negedge clk_i) begin
        if (exp_q.size() != 0) begin
            cur = exp_q.pop_front();
            check(names[cur.id], obs[cur.id], cur.v);
        end
    end
    task automatic end_of_test();
        $display("checks_done %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic want(input int id, input logic [31:0] v);
        exp_q.push_back('{id, v});
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_write_i <= 1'b1;
        @(posedge clk_i);
        reg_write_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] d);
        reg_addr_i <= a;
        repeat (2) @(posedge clk_i);
        want(0, {24'h0, d});
    endtask
    // Bounded wait for n word-clock rises (t=0) or frame ticks (t=1)
    task automatic waitn(input bit t, input int n);
        int base;
        base = t ? tn : wn;
        for (int k = 0; (t ? tn : wn) < base + n; k++) begin
            if (k > 20000) begin
                failures++;
                end_of_test();
            end
            @(posedge clk_i);
        end
    endtask
    initial begin
        logic [7:0] r;
        void'($urandom(58));
        repeat (4) @(posedge clk_i);
        reset_n_i <= 1'b1;
        @(posedge clk_i);
        rd(7'h06, 8'h00);
        rd(7'h07, 8'h00);
        wr(7'h06, 8'h0B);
        rd(7'h06, 8'h0B);
        r = 8'($urandom);
        wr(7'h08, r);
        rd(7'h08, 8'h00);
        wr(7'h07, r);
        rd(7'h07, r);
        // Word and bit clock rates for every divider on source 0, and for divider 0 on sources 1 and 2
        for (int s = 0; s < 3; s++) begin
            for (int d = 0; d < 4; d++) begin
                if (s == 0 || d == 0) begin
                    wr(7'h06, 8'(s * 4 + d));
                    waitn(1'b0, 3);
                    want(1, (d + 1) * 128 * (8 - 2 * s));
                    want(2, (d + 1) * 2 * (8 - 2 * s));
                end
            end
        end
        // Transmitter frame rate, odd codes use the recovered clock
        for (int c = 0; c < 4; c++) begin
            wr(7'h07, 8'((c % 2) * 128 + c * 32));
            waitn(1'b1, 3);
            want(3, (c + 1) * 128 * (c % 2 ? 4 : 8));
        end
        for (int s = 0; s < 4; s++) begin
            wr(7'h07, 8'(s * 8));
            aud <= 3'($urandom);
            repeat (3) @(posedge clk_i);
            want(4, s == 3 ? 1'b0 : aud[s]);
            want(5, s);
        end
        for (int k = 0; k < 4; k++) begin
            wr(7'h07, 8'((k % 2) * 2));
            usel <= k / 2;
            sval <= 1'($urandom);
            repeat (2) @(posedge clk_i);
            want(6, k / 2 ? k % 2 : sval);
        end
        wr(7'h07, 8'h04);
        want(8, 1);
        waitn(1'b1, 2);
        want(9, 0);
        wr(7'h07, 8'h00);
        slip <= 1'b1;
        @(posedge clk_i);
        slip <= 1'b0;
        @(posedge clk_i);
        want(7, 1);
        clr <= 1'b1;
        @(posedge clk_i);
        clr <= 1'b0;
        @(posedge clk_i);
        want(7, 0);
        // Block start trigger: slips are ignored, a pin rise sets the flag
        wr(7'h07, 8'h01);
        slip <= 1'b1;
        @(posedge clk_i);
        slip <= 1'b0;
        repeat (2) @(posedge clk_i);
        want(7, 0);
        bs_pin <= 1'b1;
        repeat (6) @(posedge clk_i);
        want(7, 1);
        smode <= 1'b0;
        repeat (8) @(posedge clk_i);
        end_of_test();
    end
endmodule
bind pctcr_top pctcr_props pctcr_props_inst (.clk_i(clk_i),
    .reset_n_i(reset_n_i), .reg_write_i(reg_write_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o),
    .secondary_master_mode_i(secondary_master_mode_i),
    .secondary_bit_clock_o(secondary_bit_clock_o),
    .secondary_word_clock_o(secondary_word_clock_o),
    .usability_source_select_i(usability_source_select_i),
    .stream_validity_i(stream_validity_i), .tx_validity_o(tx_validity_o),
    .data_slip_i(data_slip_i), .slip_flag_clear_i(slip_flag_clear_i),
    .transmitter_slip_flag_o(transmitter_slip_flag_o),
    .block_start_pin_oe_o(block_start_pin_oe_o),
    .transmitter_input_select_o(transmitter_input_select_o));
